// File: hw/serial_audio_placement_map.svh
// register offsets, field positions, reset values and limits
`ifndef SERIAL_AUDIO_PLACEMENT_MAP_SVH
`define SERIAL_AUDIO_PLACEMENT_MAP_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_PLACE 12'h004
`define OFS_VI 12'h008
`define OFS_AUX 12'h00c
`define OFS_AUDIO 12'h010
`define OFS_SYNC 12'h014
// ---------------------------------------------------------------
// reset values and writable masks
// ---------------------------------------------------------------
`define RST_CTRL 32'h0000_0000
`define RST_PLACE 32'h1ffe_88fc
`define RST_VI 32'h0000_0000
`define RST_AUX 32'h0000_0000
`define MASK_CTRL 32'h0000_0f3f
`define MASK_AUX 32'h00ff_ffff
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_EDGE 0
`define CTRL_FSPOL 1
`define CTRL_FMT 2
`define CTRL_TDM 3
`define CTRL_MCHIP 4
`define CTRL_DRIVE 5
`define CTRL_SLOT_LSB 8
`define PLACE_IN_LSB 0
`define PLACE_SNS_LSB 8
`define PLACE_EN_LSB 26
`define VI_CURR_LSB 16
`define AUX_CTRL_LSB 8
`define AUX_STATUS_LSB 16
// ---------------------------------------------------------------
// placement counts and lengths in bit-clock cycles
// ---------------------------------------------------------------
`define IN_PLACES 3'd4
`define OUT_PLACES 3'd6
`define LEN_24 5'd24
`define LEN_16 5'd16
`define LEN_8 5'd8
`endif

// File: hw/serial_audio_placement_pkg.sv
// types and length helpers for the serial audio placement block
package serial_audio_placement_pkg;
  `include "serial_audio_placement_map.svh"
  typedef enum logic [1:0] {
    IN_AUDIO24 = 2'b00,
    IN_AUDIO16 = 2'b01,
    IN_PAD8 = 2'b10,
    IN_UNUSED = 2'b11
  } input_sel_t;
  typedef enum logic [2:0] {
    SNS_VOLT = 3'b000,
    SNS_CURR = 3'b001,
    SNS_BATT = 3'b010,
    SNS_CTRL = 3'b011,
    SNS_ALT = 3'b100,
    SNS_STATUS = 3'b101,
    SNS_MARKER = 3'b110,
    SNS_ZERO = 3'b111
  } sense_sel_t;
  typedef struct packed {
    logic [5:0] senseEn;
    logic [17:0] senseSel;
    logic [7:0] inputSel;
    logic [3:0] markerSlot;
    logic unusedDrive;
    logic multichipEn;
    logic portFormat;
    logic dataFormat;
    logic fsPolarity;
    logic bitClockEdge;
    logic [15:0] volt;
    logic [15:0] curr;
    logic [7:0] batt;
    logic [7:0] ctrlByte;
    logic [7:0] statusByte;
  } link_cfg_t;
  function automatic logic [4:0] inLen(input input_sel_t s);
    return (s == IN_AUDIO24) ? `LEN_24 :
           (s == IN_AUDIO16) ? `LEN_16 : `LEN_8;
  endfunction
  function automatic logic [4:0] senseLen(input sense_sel_t s);
    return (s == SNS_VOLT || s == SNS_CURR || s == SNS_ALT) ?
           `LEN_16 : `LEN_8;
  endfunction
endpackage

// File: hw/serial_audio_placement.sv
// slot placement logic of a slave serial audio port with apb setup
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "serial_audio_placement_map.svh"
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module serial_audio_placement (
  // system clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link on the host bit clock
  input wire logic bitClk,
  input wire logic frameSync,
  input wire logic audioIn,
  output logic senseOut,
  output logic senseOutOe
);

  // ---------------------------------------------------------------
  // apb register file
  // ---------------------------------------------------------------
  logic [31:0] ctrlReg;
  logic [31:0] placeReg;
  logic [31:0] viReg;
  logic [31:0] auxReg;
  logic [23:0] audioWord;
  logic [7:0] audioCount;
  logic pending;
  serial_audio_placement_pkg::link_cfg_t liveCfg;
  logic [31:0] rdMux;

  // address decode
  wire apbAccess = psel & penable;
  wire apbWrite = apbAccess & pwrite;
  wire hitCtrl = (paddr == `OFS_CTRL);
  wire hitPlace = (paddr == `OFS_PLACE);
  wire hitVi = (paddr == `OFS_VI);
  wire hitAux = (paddr == `OFS_AUX);
  wire hitAudio = (paddr == `OFS_AUDIO);
  wire hitSync = (paddr == `OFS_SYNC);
  wire mapped = hitCtrl | hitPlace | hitVi | hitAux | hitAudio | hitSync;
  wire cfgWrite = apbWrite & (hitCtrl | hitPlace | hitVi | hitAux);

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = apbAccess & ~mapped;

  // read selection, unmapped reads return zero
  assign rdMux = hitCtrl ? ctrlReg :
                 hitPlace ? placeReg :
                 hitVi ? viReg :
                 hitAux ? auxReg :
                 hitAudio ? {audioCount, audioWord} :
                 hitSync ? {31'h0, pending} : 32'h0;

  // writable registers; reset gives the standard stereo setup
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrlReg <= `RST_CTRL;
      placeReg <= `RST_PLACE;
      viReg <= `RST_VI;
      auxReg <= `RST_AUX;
    end else if (apbWrite) begin
      if (hitCtrl) ctrlReg <= pwdata & `MASK_CTRL;
      if (hitPlace) placeReg <= pwdata;
      if (hitVi) viReg <= pwdata;
      if (hitAux) auxReg <= pwdata & `MASK_AUX;
    end
  end

  // read data is captured in the setup cycle, valid in the access cycle
  always_ff @(posedge clk) begin
    if (sys_rst) prdata <= 32'h0;
    else if (psel & ~penable) prdata <= rdMux;
  end

  // gather the register fields into the link configuration
  assign liveCfg = '{
    senseEn: placeReg[`PLACE_EN_LSB +: 6],
    senseSel: placeReg[`PLACE_SNS_LSB +: 18],
    inputSel: placeReg[`PLACE_IN_LSB +: 8],
    markerSlot: ctrlReg[`CTRL_SLOT_LSB +: 4],
    unusedDrive: ctrlReg[`CTRL_DRIVE],
    multichipEn: ctrlReg[`CTRL_MCHIP],
    portFormat: ctrlReg[`CTRL_TDM],
    dataFormat: ctrlReg[`CTRL_FMT],
    fsPolarity: ctrlReg[`CTRL_FSPOL],
    bitClockEdge: ctrlReg[`CTRL_EDGE],
    volt: viReg[15:0],
    curr: viReg[`VI_CURR_LSB +: 16],
    batt: auxReg[7:0],
    ctrlByte: auxReg[`AUX_CTRL_LSB +: 8],
    statusByte: auxReg[`AUX_STATUS_LSB +: 8]
  };

  // ---------------------------------------------------------------
  // configuration crossing, toggle handshake into the bit-clock domain
  // ---------------------------------------------------------------
  serial_audio_placement_pkg::link_cfg_t xferCfg;
  logic reqTgl;
  logic ackSync1;
  logic ackSync2;
  logic reqSync1;
  logic reqSync2;
  logic reqSync3;
  wire busy = reqTgl ^ ackSync2;

  // the copy stays frozen while a request is in flight, so the link
  // side never samples a word that is changing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xferCfg <= '0;
      reqTgl <= 1'b0;
      pending <= 1'b1;
    end else begin
      if (~busy & pending) begin
        xferCfg <= liveCfg;
        reqTgl <= ~reqTgl;
        pending <= 1'b0;
      end
      if (cfgWrite) pending <= 1'b1; // a new write wins over the copy
    end
  end

  // acknowledge back into the system domain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ackSync1 <= 1'b0;
      ackSync2 <= 1'b0;
    end else begin
      ackSync1 <= reqSync3;
      ackSync2 <= ackSync1;
    end
  end

  // ---------------------------------------------------------------
  // bit-clock domain reset and configuration capture
  // ---------------------------------------------------------------
  logic linkRstSync;
  logic linkRst;
  serial_audio_placement_pkg::link_cfg_t lcfg;

  // reset is only seen while the bit clock runs
  always_ff @(posedge bitClk) begin
    linkRstSync <= sys_rst;
    linkRst <= linkRstSync;
  end

  // request toggle synchroniser; third stage marks the change
  always_ff @(posedge bitClk) begin
    if (linkRst) begin
      reqSync1 <= 1'b0;
      reqSync2 <= 1'b0;
      reqSync3 <= 1'b0;
      lcfg <= '0;
    end else begin
      reqSync1 <= reqTgl;
      reqSync2 <= reqSync1;
      reqSync3 <= reqSync2;
      if (reqSync2 ^ reqSync3) lcfg <= xferCfg;
    end
  end

  // ---------------------------------------------------------------
  // frame sync edges
  // ---------------------------------------------------------------
  logic fsPrev;
  logic fsPrev2;
  logic audioNeg;

  // host data is synchronous to the bit clock, so no synchroniser
  always_ff @(posedge bitClk) begin
    fsPrev <= frameSync;
    fsPrev2 <= fsPrev;
  end

  // falling-edge sample for the alternate latch edge
  always_ff @(negedge bitClk) audioNeg <= audioIn;

  wire tdm = lcfg.portFormat;
  wire [2:0] step = tdm ? 3'd1 : 3'd2;
  wire dataBit = lcfg.bitClockEdge ? audioNeg : audioIn;

  // output side sees the raw sync one cycle ahead of the data bit
  wire sEvt = tdm ? (frameSync & ~fsPrev) : (frameSync ^ fsPrev);
  wire sLeft = (frameSync == lcfg.fsPolarity);
  wire sStart = sEvt & (tdm | sLeft);
  wire [2:0] sStartP = (tdm | sLeft) ? 3'd0 : 3'd1;

  // input side aligns sync with the bit that it carries
  wire aCur = lcfg.dataFormat ? frameSync : fsPrev;
  wire aPrev = lcfg.dataFormat ? fsPrev : fsPrev2;
  wire iEvt = tdm ? (aCur & ~aPrev) : (aCur ^ aPrev);
  wire iLeft = (aCur == lcfg.fsPolarity);
  wire iStart = iEvt & (tdm | iLeft);
  wire [2:0] iStartP = (tdm | iLeft) ? 3'd0 : 3'd1;

  // ---------------------------------------------------------------
  // input placement walker
  // ---------------------------------------------------------------
  logic [2:0] inP;
  logic [4:0] inBit;
  logic inAct;
  logic [22:0] audioSh;
  logic [23:0] audioHold;
  logic audioTgl;
  serial_audio_placement_pkg::input_sel_t curISel;

  // the event cycle itself carries bit 0 of the first placement
  wire [2:0] curIP = iEvt ? iStartP : inP;
  wire [4:0] curIBit = iEvt ? 5'd0 : inBit;
  wire curIAct = iEvt | inAct;
  assign curISel = serial_audio_placement_pkg::input_sel_t'(
    lcfg.inputSel[{curIP[1:0], 1'b0} +: 2]);
  wire iLive = curIAct & (curIP < `IN_PLACES) &
               (curISel != serial_audio_placement_pkg::IN_UNUSED);
  wire iLast = curIBit ==
    serial_audio_placement_pkg::inLen(curISel) - 5'd1;
  wire isA24 = curISel == serial_audio_placement_pkg::IN_AUDIO24;
  wire isA16 = curISel == serial_audio_placement_pkg::IN_AUDIO16;

  // placement position; an unused slot ends the walk until the next sync event
  always_ff @(posedge bitClk) begin
    if (linkRst) begin
      inP <= 3'd0;
      inBit <= 5'd0;
      inAct <= 1'b0;
    end else if (~iLive) begin
      inP <= curIP;
      inBit <= 5'd0;
      inAct <= 1'b0;
    end else if (iLast) begin
      inP <= curIP + step;
      inBit <= 5'd0;
      inAct <= 1'b1;
    end else begin
      inP <= curIP;
      inBit <= curIBit + 5'd1;
      inAct <= 1'b1;
    end
  end

  // audio shift; pad placements are read and thrown away
  always_ff @(posedge bitClk) begin
    if (linkRst) begin
      audioSh <= 23'h0;
      audioHold <= 24'h0;
      audioTgl <= 1'b0;
    end else if (iLive & (isA24 | isA16)) begin
      if (~iLast) audioSh <= {audioSh[21:0], dataBit};
      else begin
        audioHold <= isA24 ? {audioSh, dataBit} :
                     {audioSh[14:0], dataBit, 8'h00};
        audioTgl <= ~audioTgl;
      end
    end
  end

  // ---------------------------------------------------------------
  // audio word back into the system domain
  // ---------------------------------------------------------------
  logic audSync1;
  logic audSync2;
  logic audSync3;

  // the held word stays put for a whole placement, far longer than
  // the three system cycles needed to take it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      audSync1 <= 1'b0;
      audSync2 <= 1'b0;
      audSync3 <= 1'b0;
      audioWord <= 24'h0;
      audioCount <= 8'h0;
    end else begin
      audSync1 <= audioTgl;
      audSync2 <= audSync1;
      audSync3 <= audSync2;
      if (audSync2 ^ audSync3) begin
        audioWord <= audioHold;
        audioCount <= audioCount + 8'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // sense placement walker, one cycle ahead of the pin
  // ---------------------------------------------------------------
  logic [2:0] snP;
  logic [4:0] snBit;
  logic snAct;
  logic altPhase;
  logic [15:0] word;
  serial_audio_placement_pkg::sense_sel_t curSSel;

  wire [2:0] curSP = sEvt ? sStartP : snP;
  wire [4:0] curSBit = sEvt ? 5'd0 : snBit;
  wire curSAct = sEvt | snAct;
  wire spOk = curSP < `OUT_PLACES;
  wire [2:0] spSafe = spOk ? curSP : 3'd0;
  wire [4:0] sIdx = 5'(spSafe) * 5'd3;
  assign curSSel = serial_audio_placement_pkg::sense_sel_t'(
    lcfg.senseSel[sIdx +: 3]);
  wire sLive = curSAct & spOk & lcfg.senseEn[spSafe];
  wire sLast = curSBit ==
    serial_audio_placement_pkg::senseLen(curSSel) - 5'd1;

  // item selection, msb aligned in a 16-bit word
  always_comb begin
    case (curSSel)
      serial_audio_placement_pkg::SNS_VOLT: word = lcfg.volt;
      serial_audio_placement_pkg::SNS_CURR: word = lcfg.curr;
      serial_audio_placement_pkg::SNS_BATT:
        word = {lcfg.batt, 8'h00};
      serial_audio_placement_pkg::SNS_CTRL: word = {lcfg.ctrlByte, 8'h00};
      serial_audio_placement_pkg::SNS_ALT:
        word = altPhase ? lcfg.curr : lcfg.volt;
      serial_audio_placement_pkg::SNS_STATUS:
        word = {lcfg.statusByte, 8'h00};
      serial_audio_placement_pkg::SNS_MARKER:
        word = {altPhase, 3'b000, lcfg.markerSlot, 8'h00};
      default: word = 16'h0000; // eight zero bits
    endcase
  end

  // position update; the walk runs on through disabled placements and ends past the last one
  always_ff @(posedge bitClk) begin
    if (linkRst) begin
      snP <= 3'd0;
      snBit <= 5'd0;
      snAct <= 1'b0;
    end else if (~curSAct | ~spOk) begin
      snP <= curSP;
      snBit <= 5'd0;
      snAct <= 1'b0;
    end else if (sLast) begin
      snP <= curSP + step;
      snBit <= 5'd0;
      snAct <= 1'b1;
    end else begin
      snP <= curSP;
      snBit <= curSBit + 5'd1;
      snAct <= 1'b1;
    end
  end

  // voltage and current alternate from frame to frame
  always_ff @(posedge bitClk) begin
    if (linkRst) altPhase <= 1'b0;
    else if (sStart) altPhase <= ~altPhase;
  end

  // pin launch; release the line between placements unless asked
  always_ff @(posedge bitClk) begin
    if (linkRst) begin
      senseOut <= 1'b0;
      senseOutOe <= 1'b0;
    end else begin
      senseOut <= sLive & word[4'd15 - curSBit[3:0]];
      senseOutOe <= sLive | lcfg.unusedDrive;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_tdm_first: assert property (@(posedge bitClk) disable iff (linkRst)
    (tdm && sEvt && sLive) |=> (snP == 3'd0 && snBit == 5'd1))
    else $error("tdm walk did not start at first placement");
  a_stereo_right: assert property (@(posedge bitClk)
    disable iff (linkRst)
    (!tdm && sEvt && !sLeft && sLive) |=> (snP == 3'd1))
    else $error("right half did not start at second placement");
  a_len_step: assert property (@(posedge bitClk) disable iff (linkRst)
    (sLive && sLast) |=>
    (snBit == 5'd0 && snP == $past(curSP) + $past(step)))
    else $error("placement length or order wrong");
  a_idle_hiz: assert property (@(posedge bitClk) disable iff (linkRst)
    (!sLive && !lcfg.unusedDrive) |=> !senseOutOe)
    else $error("unused cycle driven while release selected");
  a_idle_drive: assert property (@(posedge bitClk)
    disable iff (linkRst)
    lcfg.unusedDrive |=> senseOutOe)
    else $error("unused cycle released while drive selected");
  a_frame_restart: assert property (@(posedge bitClk)
    disable iff (linkRst)
    iStart |=> (inP == 3'd0))
    else $error("input walk not restarted at frame start");
  a_no_capture: assert property (@(posedge bitClk)
    disable iff (linkRst)
    !iLive |=> $stable(audioTgl))
    else $error("audio captured outside a used placement");
  a_alt_toggle: assert property (@(posedge bitClk)
    disable iff (linkRst)
    sStart |=> (altPhase != $past(altPhase)))
    else $error("alternating item did not switch at frame start");
  a_msb_delay: assert property (@(posedge bitClk) disable iff (linkRst)
    (sEvt && !lcfg.dataFormat) ##1 $stable(lcfg) |-> iEvt)
    else $error("msb not one bit clock after sync transition");
  a_rise_latch: assert property (@(posedge bitClk)
    disable iff (linkRst)
    (iLive && iLast && isA24 && !lcfg.bitClockEdge) |=>
    (audioHold[0] == $past(audioIn)))
    else $error("audio bit not latched on rising edge");
  a_apb_error: assert property (@(posedge clk) disable iff (sys_rst)
    (apbWrite && !mapped) |=>
    ($stable(ctrlReg) && $stable(placeReg)))
    else $error("unmapped write changed configuration");

endmodule // serial_audio_placement

// File: dv/host_port_model.sv
// host side of the serial audio link: clocks, sync, audio, capture
`timescale 1ns/1ps
module host_port_model (
  // lines driven by the host
  output logic bitClk,
  output logic frameSync,
  output logic audioIn,
  // sense lines from the device
  input wire logic senseOut,
  input wire logic senseOutOe
);
  logic [63:0] capD;
  logic [63:0] capOe;
  // bit clock runs free; the port is clocked by it, offset phase
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b1;
    audioIn = 1'b0;
    #17;
    forever #62.5 bitClk = ~bitClk;
  end
  // ---------------------------------------------------------------
  // one frame of 64 bit clocks
  // ---------------------------------------------------------------
  // lines move on falling edges, sense is latched on rising edges;
  // audio outside the 24 data cycles toggles so it is never stale
  // f is the cycle that carries the msb: 1 when it lags the sync edge
  task automatic run_frame(input logic tdm, input logic [23:0] w,
    input int f);
    for (int i = 0; i < 64; i++) begin
      @(negedge bitClk);
      frameSync <= tdm ? (i == 0) : (i >= 32);
      audioIn <= (i >= f && i < f + 24) ? w[f + 23 - i] : ~audioIn;
      @(posedge bitClk);
      if (i > 0) begin
        capD[64 - i] = senseOut; // msb-first store
        capOe[64 - i] = senseOutOe;
      end
    end
  endtask
endmodule // host_port_model

// File: dv/serial_audio_placement_bench.sv
// self-checking bench for the serial audio placement block
`timescale 1ns/1ps
`include "serial_audio_placement_map.svh"
module serial_audio_placement_bench;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bitClk;
  logic frameSync;
  logic audioIn;
  logic senseOut;
  logic senseOutOe;
  int err_total = 0;
  int cmp_count = 0;
  logic [31:0] q;
  logic [31:0] q1;
  logic e;
  logic ph;
  // 100 mhz system clock
  always #5 clk = ~clk;
  serial_audio_placement dut_u (
    .clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bitClk(bitClk), .frameSync(frameSync), .audioIn(audioIn),
    .senseOut(senseOut), .senseOutOe(senseOutOe));
  host_port_model model_u (
    .bitClk(bitClk), .frameSync(frameSync), .audioIn(audioIn),
    .senseOut(senseOut), .senseOutOe(senseOutOe));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // apb cycle; an edge passes first so no line is set twice at once
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rq, output logic re);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; the wait ends on pready, and only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask
  // config needs to cross into the bit clock domain before a frame
  task automatic settle();
    int n;
    n = 0;
    do begin
      xfer(1'b0, `OFS_SYNC, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    chk(q, 32'h0);
    // pending clears when the copy leaves; it lands a few bit clocks on
    repeat (4) @(posedge bitClk);
  endtask
  // captured field at frame position p, n bits, msb first, driven
  task automatic fld(input int p, input int n, input logic [31:0] x);
    chk(32'((model_u.capD >> (64 - p - n)) & ((64'h1 << n) - 1)), x);
    chk(32'((model_u.capOe >> (64 - p - n)) & ((64'h1 << n) - 1)),
      (32'h1 << n) - 1);
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    // held long enough for three bit clock edges as well
    repeat (40) @(posedge clk);
    sysRst <= 1'b0;
    rd(`OFS_CTRL, `RST_CTRL);
    rd(`OFS_PLACE, `RST_PLACE);
    rd(`OFS_VI, `RST_VI);
    rd(`OFS_AUX, `RST_AUX);
    settle();
    xfer(1'b1, 12'h018, 32'hffff_ffff, q, e);
    chk({31'h0, e}, 32'h1);
    rd(`OFS_CTRL, `RST_CTRL);
    xfer(1'b0, 12'h018, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(`OFS_AUX, 32'hffff_ffff);
    rd(`OFS_AUX, `MASK_AUX);
    wr(`OFS_VI, 32'h5a3c_c3a5);
    wr(`OFS_AUX, 32'h0069_3c96);
    settle();
    // default stereo frame: v and battery left, current right
    model_u.run_frame(1'b0, 24'habcdef, 1);
    fld(0, 16, 32'hc3a5);
    fld(16, 8, 32'h96);
    chk({31'h0, model_u.capOe[39]}, 32'h0);
    fld(32, 16, 32'h5a3c);
    xfer(1'b0, `OFS_AUDIO, 32'h0, q, e);
    chk({8'h0, q[23:0]}, 32'h00ab_cdef);
    // unused cycles driven low when asked
    wr(`OFS_CTRL, 32'h0000_0020);
    settle();
    model_u.run_frame(1'b0, 24'h123456, 1);
    fld(24, 8, 32'h0);
    // swapped polarity, msb at the edge: left half is the high phase
    wr(`OFS_CTRL, 32'h0000_0006);
    settle();
    model_u.run_frame(1'b0, 24'h2468ac, 32);
    fld(0, 16, 32'h5a3c);
    fld(32, 16, 32'hc3a5);
    xfer(1'b0, `OFS_AUDIO, 32'h0, q, e);
    chk({8'h0, q[23:0]}, 32'h0024_68ac);
    // tdm: in pad8,aud16; out ctrl,alt,status,marker,zero,batt
    wr(`OFS_CTRL, 32'h0000_0a08);
    wr(`OFS_PLACE, 32'hfd7d_63f6);
    settle();
    model_u.run_frame(1'b1, 24'h0, 1); // resync after the mode change
    model_u.run_frame(1'b1, 24'h5ab1c2, 1);
    xfer(1'b0, `OFS_AUDIO, 32'h0, q1, e);
    chk({8'h0, q1[23:0]}, 32'h00b1_c200);
    ph = model_u.capD[31]; // marker top bit tells the phase
    fld(0, 8, 32'h3c);
    fld(8, 16, ph ? 32'h5a3c : 32'hc3a5);
    fld(24, 8, 32'h69);
    fld(32, 8, {24'h0, ph, 7'h0a});
    fld(40, 8, 32'h0);
    fld(48, 8, 32'h96);
    chk({31'h0, model_u.capOe[7]}, 32'h0);
    model_u.run_frame(1'b1, 24'h00f00d, 1);
    fld(8, 16, ph ? 32'hc3a5 : 32'h5a3c);
    fld(32, 8, {24'h0, ~ph, 7'h0a});
    xfer(1'b0, `OFS_AUDIO, 32'h0, q, e);
    chk({24'h0, q[31:24]}, {24'h0, q1[31:24] + 8'h1});
    chk({8'h0, q[23:0]}, 32'h00f0_0d00);
    close_out();
  end
  // watchdog: six frames and the bus work fit well inside this
  initial begin
    #500000;
    err_total++;
    close_out();
  end
endmodule // serial_audio_placement_bench
